// ===== logic/sbs_status.sv
/*
 SMBus status register with strapped addresses, expander address, load done flag
 and write-one-to-clear error flags, plus the arbitration retry sequencer.
 Assumes event inputs are one-cycle pulses synchronous to core_clk and that the
 register port is driven by the internal configuration access path, fed by both
 the slave SMBus and internal software.
*/
module sbs_status
   import sbs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Straps, sampled after reset release
   input wire logic [6:0] target_port_address,
   input wire logic [6:0] initiator_port_address,
   input wire logic prom_load_mode,
   // Register port (slave SMBus and internal software share it)
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic expander_write_lock,
   output logic [31:0] reg_rdata,
   // Control bits from the control register
   input wire logic [31:0] smbus_control,
   // Initiator port events
   input wire logic arb_request,
   input wire logic arb_won,
   input wire logic arb_lost,
   input wire logic xfer_done,
   input wire logic nack_seen,
   input wire logic misplaced_condition,
   // Prom loader events
   input wire logic load_finished,
   input wire logic load_error,
   input wire logic load_csum_bad,
   input wire logic load_no_done_cmd,
   input wire logic load_unmapped_write,
   // Arbitration results toward the initiator port
   output logic arb_retry,
   output logic arb_proceed,
   output logic arb_abort
);
   logic [6:0] tgt_addr_reg;
   logic [6:0] ini_addr_reg;
   logic load_mode_reg;
   logic strap_taken_reg;
   logic [6:0] exp_addr_reg;
   logic load_done_reg;
   logic nack_err_reg;
   logic arb_err_reg;
   logic cond_err_reg;
   logic csum_err_reg;
   logic unmap_err_reg;
   logic [4:0] loss_cnt_reg;
   logic [4:0] loss_cnt_next;
   sbs_arb_state_t arb_state_reg;
   logic [31:0] status_value;
   logic disregard_arbitration;
   logic skip_checksum_check;
   logic arb_abort_event;

   assign disregard_arbitration = smbus_control[CTL_DISREGARD_ARB_BIT];
   assign skip_checksum_check = smbus_control[CTL_SKIP_CSUM_BIT];
   assign loss_cnt_next = loss_cnt_reg + ARB_RETRY_INC;
   assign arb_abort_event = (arb_state_reg == ARB_WAIT) && arb_lost && !disregard_arbitration
                            && (loss_cnt_next == ARB_RETRY_LIMIT);

   // Sticky flag update: set wins over a write-one clear
   function automatic logic sticky(input logic cur, input logic set_ev, input logic clr);
      sticky = set_ev | (cur & ~clr);
   endfunction

   // Straps caught once after reset release
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tgt_addr_reg <= 7'h00;
         ini_addr_reg <= 7'h00;
         load_mode_reg <= 1'b0;
         strap_taken_reg <= 1'b0;
      end else if (!strap_taken_reg) begin
         tgt_addr_reg <= target_port_address;
         ini_addr_reg <= initiator_port_address;
         load_mode_reg <= prom_load_mode;
         strap_taken_reg <= 1'b1;
      end
   end

   // Expander address
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         exp_addr_reg <= EXP_ADDR_RESET;
      end else if (reg_wr && !expander_write_lock) begin
         exp_addr_reg <= reg_wdata[EXP_ADDR_LSB +: ADDR_WIDTH];
      end
   end

   // Load done flag
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_done_reg <= 1'b0;
      end else if (load_mode_reg && (load_finished || load_error)) begin
         load_done_reg <= 1'b1;
      end
   end

   // Error flags
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nack_err_reg <= 1'b0;
         arb_err_reg <= 1'b0;
         cond_err_reg <= 1'b0;
         csum_err_reg <= 1'b0;
         unmap_err_reg <= 1'b0;
      end else begin
         nack_err_reg <= sticky(nack_err_reg, nack_seen, reg_wr & reg_wdata[NACK_ERR_BIT]);
         arb_err_reg <= sticky(arb_err_reg, arb_abort_event, reg_wr & reg_wdata[ARB_ERR_BIT]);
         cond_err_reg <= sticky(cond_err_reg, misplaced_condition, reg_wr & reg_wdata[COND_ERR_BIT]);
         csum_err_reg <= sticky(csum_err_reg, !skip_checksum_check && (load_csum_bad || load_no_done_cmd),
                                reg_wr & reg_wdata[CSUM_ERR_BIT]);
         unmap_err_reg <= sticky(unmap_err_reg, load_unmapped_write, reg_wr & reg_wdata[UNMAP_ERR_BIT]);
      end
   end

   // Arbitration sequencer
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         arb_state_reg <= ARB_IDLE;
         loss_cnt_reg <= ARB_RETRY_ZERO;
         arb_retry <= 1'b0;
         arb_proceed <= 1'b0;
         arb_abort <= 1'b0;
      end else begin
         arb_retry <= 1'b0;
         arb_proceed <= 1'b0;
         arb_abort <= 1'b0;
         case (arb_state_reg)
            ARB_IDLE: begin
               loss_cnt_reg <= ARB_RETRY_ZERO;
               if (arb_request) begin
                  arb_state_reg <= ARB_WAIT;
               end
            end
            ARB_WAIT: begin
               if (arb_won || (arb_lost && disregard_arbitration)) begin
                  arb_proceed <= 1'b1;
                  loss_cnt_reg <= ARB_RETRY_ZERO;
                  arb_state_reg <= ARB_OWN;
               end else if (arb_abort_event) begin
                  arb_abort <= 1'b1;
                  arb_state_reg <= ARB_ABORT;
               end else if (arb_lost) begin
                  arb_retry <= 1'b1;
                  loss_cnt_reg <= loss_cnt_next;
               end
            end
            ARB_OWN: begin
               if (xfer_done) begin
                  arb_state_reg <= ARB_IDLE;
               end
            end
            ARB_ABORT: begin
               loss_cnt_reg <= ARB_RETRY_ZERO;
               arb_state_reg <= ARB_IDLE;
            end
            default: begin
               arb_state_reg <= ARB_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      status_value = 32'h00000000;
      status_value[TGT_ADDR_LSB +: ADDR_WIDTH] = tgt_addr_reg;
      status_value[INI_ADDR_LSB +: ADDR_WIDTH] = ini_addr_reg;
      status_value[EXP_ADDR_LSB +: ADDR_WIDTH] = exp_addr_reg;
      status_value[LOAD_DONE_BIT] = load_done_reg;
      status_value[NACK_ERR_BIT] = nack_err_reg;
      status_value[ARB_ERR_BIT] = arb_err_reg;
      status_value[COND_ERR_BIT] = cond_err_reg;
      status_value[CSUM_ERR_BIT] = csum_err_reg;
      status_value[UNMAP_ERR_BIT] = unmap_err_reg;
   end

   // Read data registered one cycle after the read strobe
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= status_value & ~STS_RESERVED_MASK;
      end
   end

   sequence seq_loss;
      arb_state_reg == ARB_WAIT && arb_lost && !disregard_arbitration;
   endsequence

   // Checked only from the second edge after capture, so the capture itself is not seen as a change
   AST_STRAP_TGT: assert property (@(posedge core_clk) disable iff (sys_rst)
      $past(strap_taken_reg) |-> status_value[7:1] == tgt_addr_reg && $stable(tgt_addr_reg))
      else $error("target address changed");
   AST_STRAP_INI: assert property (@(posedge core_clk) disable iff (sys_rst)
      $past(strap_taken_reg) |-> status_value[15:9] == ini_addr_reg && $stable(ini_addr_reg))
      else $error("initiator address changed");
   AST_EXP_LOCK: assert property (@(posedge core_clk) disable iff (sys_rst)
      reg_wr && expander_write_lock |=> $stable(exp_addr_reg))
      else $error("locked expander address written");
   AST_LOAD_DONE: assert property (@(posedge core_clk) disable iff (sys_rst)
      load_mode_reg && (load_finished || load_error) |=> load_done_reg [*2])
      else $error("load done not set");
   AST_NACK_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
      nack_seen |=> nack_err_reg)
      else $error("nack flag not set");
   AST_RETRY: assert property (@(posedge core_clk) disable iff (sys_rst)
      seq_loss ##0 (loss_cnt_reg < 5'h0f) |=> arb_retry && !arb_abort)
      else $error("no retry after loss");
   AST_ABORT16: assert property (@(posedge core_clk) disable iff (sys_rst)
      seq_loss ##0 (loss_cnt_reg == 5'h0f) |=> arb_abort && arb_err_reg)
      else $error("abort missing at sixteenth loss");
   AST_COND_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
      misplaced_condition |=> cond_err_reg)
      else $error("condition flag not set");
   AST_CSUM_SKIP: assert property (@(posedge core_clk) disable iff (sys_rst)
      skip_checksum_check && !csum_err_reg |=> !csum_err_reg)
      else $error("checksum flagged while skipped");
   AST_CSUM_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
      !skip_checksum_check && (load_csum_bad || load_no_done_cmd) |=> csum_err_reg)
      else $error("checksum flag not set");
   AST_UNMAP_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
      load_unmapped_write |=> unmap_err_reg)
      else $error("unmapped flag not set");
   AST_DISREGARD: assert property (@(posedge core_clk) disable iff (sys_rst)
      arb_state_reg == ARB_WAIT && arb_lost && disregard_arbitration |=> arb_proceed)
      else $error("lost arbitration not disregarded");
   AST_RESERVED: assert property (@(posedge core_clk) disable iff (sys_rst)
      reg_rd |=> (reg_rdata & STS_RESERVED_MASK) == 32'h00000000)
      else $error("reserved bits nonzero");
   AST_STICKY: assert property (@(posedge core_clk) disable iff (sys_rst)
      nack_err_reg && !(reg_wr && reg_wdata[NACK_ERR_BIT]) |=> nack_err_reg)
      else $error("error flag dropped without clear");
endmodule

// ===== shared/sbs_pkg.sv
/*
 Status register layout, control bit positions and arbitration retry limit for the
 SMBus status block. Assumes a single core clock domain.
*/
package sbs_pkg;
   localparam int unsigned STS_WIDTH = 32;
   localparam int unsigned ADDR_WIDTH = 7;
   localparam int unsigned TGT_ADDR_LSB = 1;
   localparam int unsigned INI_ADDR_LSB = 9;
   localparam int unsigned EXP_ADDR_LSB = 17;
   localparam int unsigned LOAD_DONE_BIT = 24;
   localparam int unsigned NACK_ERR_BIT = 25;
   localparam int unsigned ARB_ERR_BIT = 26;
   localparam int unsigned COND_ERR_BIT = 27;
   localparam int unsigned CSUM_ERR_BIT = 28;
   localparam int unsigned UNMAP_ERR_BIT = 29;
   localparam int unsigned CTL_DISREGARD_ARB_BIT = 16;
   localparam int unsigned CTL_SKIP_CSUM_BIT = 17;
   localparam logic [6:0] EXP_ADDR_RESET = 7'h00;
   localparam logic [4:0] ARB_RETRY_LIMIT = 5'h10;
   localparam logic [4:0] ARB_RETRY_INC = 5'h01;
   localparam logic [4:0] ARB_RETRY_ZERO = 5'h00;
   localparam logic [31:0] STS_RESERVED_MASK = 32'hc0010101;
   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_WAIT = 2'b01,
      ARB_OWN = 2'b10,
      ARB_ABORT = 2'b11
   } sbs_arb_state_t;
endpackage

// ===== tb/sbs_far_end.sv
/*
 Far-side arbitration model for the SMBus status block: it answers each bus attempt
 with a loss until the given loss budget is used up, and with a win after that.
 Assumes one-cycle request and retry pulses that are synchronous to core_clk.
*/
module sbs_far_end (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Attempt triggers and loss budget
   input wire logic arb_request,
   input wire logic arb_retry,
   input wire logic [5:0] loss_count,
   // Arbitration outcome
   output logic arb_won,
   output logic arb_lost
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] given;
   logic lose_q;
   logic win_q;
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         given <= 6'h00;
         lose_q <= 1'b0;
         win_q <= 1'b0;
      end else if (arb_request || arb_retry) begin
         // A fresh request restarts the loss budget
         lose_q <= ((arb_request ? 6'h00 : given) < loss_count);
         win_q <= ((arb_request ? 6'h00 : given) >= loss_count);
         given <= (arb_request ? 6'h00 : given) + 6'h01;
      end else begin
         lose_q <= 1'b0;
         win_q <= 1'b0;
      end
   end
   // Outcomes launched at the falling edge, one cycle wide
   always @(negedge core_clk) begin
      arb_lost <= lose_q;
      arb_won <= win_q;
   end
endmodule

// ===== tb/sbs_status_tb.sv
/*
 Self-checking bench for the SMBus status block: register access, event flags
 and arbitration retry. Assumes sbs_far_end answers the arbitration attempts.
*/
module sbs_status_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic prom_load_mode = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic lock = 1'b0;
   logic [8:0] ev = 9'h000;
   logic [31:0] wdata = 32'h00000000;
   logic [31:0] ctl = 32'h00000000;
   logic [31:0] rdata;
   logic [6:0] tgt = 7'h2a;
   logic [6:0] ini = 7'h35;
   logic won, lost, retry, proceed, abort;
   logic [5:0] losses = 6'h00;
   int miscompares = 0;
   int compares = 0;
   int n_retry, n_proceed, n_abort;
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (retry === 1'b1) n_retry++;
      if (proceed === 1'b1) n_proceed++;
      if (abort === 1'b1) n_abort++;
   end
   sbs_status dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .target_port_address(tgt),
      .initiator_port_address(ini), .prom_load_mode(prom_load_mode), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(wdata), .expander_write_lock(lock), .reg_rdata(rdata), .smbus_control(ctl),
      .arb_request(ev[8]), .arb_won(won), .arb_lost(lost), .xfer_done(ev[7]), .nack_seen(ev[0]),
      .misplaced_condition(ev[1]), .load_finished(ev[2]), .load_error(ev[3]), .load_csum_bad(ev[4]),
      .load_no_done_cmd(ev[5]), .load_unmapped_write(ev[6]), .arb_retry(retry), .arb_proceed(proceed),
      .arb_abort(abort));
   sbs_far_end far_u (.core_clk(core_clk), .sys_rst(sys_rst), .arb_request(ev[8]), .arb_retry(retry),
      .loss_count(losses), .arb_won(won), .arb_lost(lost));
   task automatic stop_test();
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input string what, input logic [31:0] exp);
      @(negedge core_clk);
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      check(what, rdata, exp);
   endtask
   task automatic pulse(input int b);
      @(negedge core_clk);
      ev[b] = 1'b1;
      @(negedge core_clk);
      ev[b] = 1'b0;
   endtask
   // Mid-run reset with a new load mode strap
   task automatic restart(input logic mode);
      @(negedge core_clk);
      prom_load_mode = mode;
      sys_rst = 1'b1;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask
   // Runs one transaction against a loss budget and counts the outcomes
   task automatic arb(input logic [5:0] n, input int er, input int ep, input int ea);
      losses = n;
      n_retry = 0;
      n_proceed = 0;
      n_abort = 0;
      pulse(8);
      for (int i = 0; i < 200 && n_proceed + n_abort == 0; i++) @(negedge core_clk);
      if (n_proceed + n_abort == 0) begin
         miscompares++;
         stop_test();
      end
      if (ep != 0) pulse(7);
      check("retries", n_retry, er);
      check("proceeds", n_proceed, ep);
      check("aborts", n_abort, ea);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge core_clk);
      rd("reset", 32'h00006a54);
      lock = 1'b1;
      wr(32'hffffffff);
      rd("locked", 32'h00006a54);
      lock = 1'b0;
      wr(32'hc0b70101);
      rd("expander", 32'h00b66a54);
      pulse(0);
      pulse(1);
      pulse(3);
      pulse(4);
      pulse(6);
      rd("events", 32'h3bb66a54);
      wr(32'h02b60000);
      rd("clear one", 32'h39b66a54);
      wr(32'h3fb60000);
      rd("clear all", 32'h01b66a54);
      pulse(5);
      rd("no done", 32'h11b66a54);
      wr(32'h10b60000);
      ctl = 32'h00020000;
      pulse(4);
      pulse(5);
      rd("skip csum", 32'h01b66a54);
      ctl = 32'h00000000;
      arb(6'h03, 3, 1, 0);
      arb(6'h0f, 15, 1, 0);
      arb(6'h10, 15, 0, 1);
      rd("arb lost", 32'h05b66a54);
      wr(32'h04b60000);
      ctl = 32'h00010000;
      arb(6'h01, 0, 1, 0);
      rd("final", 32'h01b66a54);
      restart(1'b1);
      pulse(2);
      rd("load finished", 32'h01006a54);
      restart(1'b0);
      pulse(2);
      pulse(3);
      rd("no load mode", 32'h00006a54);
      stop_test();
   end
endmodule
